/* File: design/serial_adc_interface.sv */
// Purpose: Serial control and result port of an eight-input 12-bit SAR converter.
// Assumes: Serial pins are sampled by the 200 MHz core clock.
// Notes:   Analog comparator decision arrives as an asynchronous level.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_defines.svh"

module serial_adc_interface
(
  // Clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Serial pins
  input  wire logic        select_n_in,
  input  wire logic        sclk_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_n_out,
  output logic             conversion_strobe_out,
  output logic             conversion_strobe_oe_n_out,
  // Analog control
  input  wire logic        comparator_in,
  output logic [2:0]       pos_channel_out,
  output logic [2:0]       neg_channel_out,
  output logic             neg_to_common_out,
  output logic             track_out,
  output logic             hold_on_negative_out,
  output logic [11:0]      dac_code_out,
  output logic             polarity_select_out,
  // Register port
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             irq_out
);

  //----------------------------------------
  // Pin synchronisers
  //----------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       sclk_prev;

  // Two stages; only sync_b is read by logic
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      sync_a    <= 4'hF;
      sync_b    <= 4'hF;
      sclk_prev <= 1'b1;
    end
    else if (ce_in)
    begin
      sync_a    <= {comparator_in, din_in, sclk_in, select_n_in};
      sync_b    <= sync_a;
      sclk_prev <= sync_b[1];
    end

  logic sel_hi;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic comp_s;

  assign sel_hi    = sync_b[0];
  assign sclk_rise = sync_b[1] & ~sclk_prev;
  assign sclk_fall = ~sync_b[1] & sclk_prev;
  assign din_s     = sync_b[2];
  assign comp_s    = sync_b[3];

  //----------------------------------------
  // Frame sequencer
  //----------------------------------------
  adc_serial_pkg::state_t state;
  logic [3:0]  bit_cnt;
  logic [6:0]  ctrl;
  logic        mode_int;
  logic [11:0] result;
  logic [11:0] out_shift;
  logic [3:0]  bit_idx;
  logic [4:0]  step_cnt;
  logic        sar_step;
  logic        sar_last;
  logic        done_evt;
  logic        ctrl_evt;

  localparam logic [4:0] STEP_LAST = 5'(`INT_STEP_CYC - 1);

  // Input pair decode: differential pairs differ only in bit 0
  function automatic logic [6:0] mux_decode(input logic [2:0] sel, input logic single);
    logic [2:0] pos;
    pos = {sel[1], sel[0], sel[2]};
    if (single)
      mux_decode = {pos, 3'h0, 1'b1};
    else
      mux_decode = {pos, pos ^ 3'h1, 1'b0};
  endfunction

  assign sar_last = (bit_idx == 4'h0);
  // One decision per falling edge in external mode, per tick internally
  assign sar_step = (!mode_int && sclk_fall && !sel_hi &&
                     (state == adc_serial_pkg::ST_STROBE || state == adc_serial_pkg::ST_EXT_CONV)) ||
                    (state == adc_serial_pkg::ST_INT_CONV && step_cnt == STEP_LAST);

  // Sequencer; select high aborts unless an internal conversion runs
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      state    <= adc_serial_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      ctrl     <= 7'h00;
      mode_int <= 1'b0;
      done_evt <= 1'b0;
      ctrl_evt <= 1'b0;
      step_cnt <= 5'h00;
    end
    else if (ce_in)
    begin
      done_evt <= 1'b0;
      ctrl_evt <= 1'b0;
      if (sel_hi && state != adc_serial_pkg::ST_INT_CONV)
        state <= adc_serial_pkg::ST_IDLE;
      else
        case (state)
          adc_serial_pkg::ST_IDLE:
            if (sclk_rise && din_s)
            begin
              state   <= adc_serial_pkg::ST_CONTROL;
              bit_cnt <= 4'h1;
            end
          adc_serial_pkg::ST_CONTROL:
            if (sclk_rise && bit_cnt != `CTRL_BITS)
            begin
              ctrl    <= {ctrl[5:0], din_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (sclk_fall && bit_cnt == `CTRL_BITS)
            begin
              ctrl_evt <= 1'b1;
              mode_int <= (ctrl[1:0] == `MODE_INTERNAL);
              step_cnt <= 5'h00;
              state    <= (ctrl[1:0] == `MODE_INTERNAL) ? adc_serial_pkg::ST_INT_CONV
                                                        : adc_serial_pkg::ST_STROBE;
            end
          adc_serial_pkg::ST_STROBE:
            if (sclk_fall)
              state <= adc_serial_pkg::ST_EXT_CONV;
          adc_serial_pkg::ST_EXT_CONV:
            if (sar_step && sar_last)
            begin
              done_evt <= 1'b1;
              state    <= adc_serial_pkg::ST_IDLE;
            end
          adc_serial_pkg::ST_INT_CONV:
          begin
            step_cnt <= (step_cnt == STEP_LAST) ? 5'h00 : step_cnt + 5'h01;
            if (sar_step && sar_last)
            begin
              done_evt <= 1'b1;
              bit_cnt  <= 4'h0;
              state    <= adc_serial_pkg::ST_INT_READ;
            end
          end
          adc_serial_pkg::ST_INT_READ:
            if (sclk_fall)
            begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(`RESULT_BITS))
                state <= adc_serial_pkg::ST_IDLE;
            end
          default:
            state <= adc_serial_pkg::ST_IDLE;
        endcase
    end

  //----------------------------------------
  // Successive approximation
  //----------------------------------------
  // Trial bit stays when input is above the DAC level
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      dac_code_out <= 12'h800;
      bit_idx      <= 4'hB;
      result       <= 12'h000;
    end
    else if (ce_in)
    begin
      if (ctrl_evt)
      begin
        dac_code_out <= 12'h800;
        bit_idx      <= 4'hB;
      end
      else if (sar_step)
      begin
        dac_code_out[bit_idx] <= comp_s;
        if (!sar_last)
        begin
          dac_code_out[bit_idx - 4'h1] <= 1'b1;
          bit_idx                      <= bit_idx - 4'h1;
        end
        else
          result <= {dac_code_out[11:1], comp_s};
      end
    end

  //----------------------------------------
  // Track/hold and input multiplexer
  //----------------------------------------
  logic [6:0] mux_sel;
  assign mux_sel = mux_decode(ctrl[3:1], 1'b1);

  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      track_out            <= 1'b0;
      hold_on_negative_out <= 1'b0;
      pos_channel_out      <= 3'h0;
      neg_channel_out      <= 3'h0;
      neg_to_common_out    <= 1'b1;
      polarity_select_out  <= 1'b1;
    end
    else if (ce_in)
    begin
      if (state == adc_serial_pkg::ST_CONTROL && sclk_fall && bit_cnt == `TRACK_BIT)
      begin
        track_out <= 1'b1;
        {pos_channel_out, neg_channel_out, neg_to_common_out} <= mux_sel;
      end
      // Sixth bit settles single-ended or differential before hold
      if (state == adc_serial_pkg::ST_CONTROL && sclk_rise && bit_cnt == 4'h5)
        {pos_channel_out, neg_channel_out, neg_to_common_out} <= mux_decode(ctrl[3:1], din_s);
      if (state == adc_serial_pkg::ST_CONTROL && sclk_rise && bit_cnt == 4'h4)
        polarity_select_out <= din_s;
      if (ctrl_evt)
      begin
        track_out            <= 1'b0;
        hold_on_negative_out <= 1'b1;
      end
      else if (done_evt || (sel_hi && state != adc_serial_pkg::ST_INT_CONV))
      begin
        hold_on_negative_out <= 1'b0;
        track_out            <= 1'b0;
      end
    end

  //----------------------------------------
  // Output pins
  //----------------------------------------
  // Data changes only on falling edges; strobe resets low
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      dout_out              <= 1'b0;
      out_shift             <= 12'h000;
      conversion_strobe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (ctrl_evt)
        conversion_strobe_out <= (ctrl[1:0] != `MODE_INTERNAL);
      else if (state == adc_serial_pkg::ST_STROBE && sclk_fall)
        conversion_strobe_out <= 1'b0;
      else if (done_evt && mode_int) // Done pulse lands after the state has moved on
        conversion_strobe_out <= 1'b1;
      if (done_evt && mode_int)
        out_shift <= result;
      if (sar_step && !mode_int)
        dout_out <= comp_s;
      else if (sclk_fall && state == adc_serial_pkg::ST_INT_READ)
      begin
        dout_out  <= out_shift[11];
        out_shift <= {out_shift[10:0], 1'b0};
      end
      else if (sclk_fall && state == adc_serial_pkg::ST_IDLE)
        dout_out <= 1'b0;
    end

  // Data driver released while select is high; strobe driver released then only in external clock mode
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      dout_oe_n_out              <= 1'b1;
      conversion_strobe_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      dout_oe_n_out              <= sel_hi;
      conversion_strobe_oe_n_out <= sel_hi && !mode_int;
    end

  //----------------------------------------
  // Register port and interrupt
  //----------------------------------------
  logic [1:0] status;
  logic [1:0] mask;

  // Status clears on read; a new event in that cycle wins
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      status        <= 2'h0;
      mask          <= `MASK_RESET;
      reg_rdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      status <= ((reg_rd_in && reg_addr_in == `REG_STATUS) ? 2'h0 : status) | {ctrl_evt, done_evt};
      if (reg_wr_in && reg_addr_in == `REG_MASK)
        mask <= reg_wdata_in[1:0];
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in)
        case (reg_addr_in)
          `REG_STATUS: reg_rdata_out <= {30'h0, status};
          `REG_MASK:   reg_rdata_out <= {30'h0, mask};
          `REG_RESULT: reg_rdata_out <= {13'h0, ctrl, result};
          default:     reg_rdata_out <= 32'h0000_0000;
        endcase
    end

  assign irq_out = |(status & mask);

  //----------------------------------------
  // Assertions
  //----------------------------------------
  logic [1:0] acq_cnt;

  // Falling edges seen while tracking
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      acq_cnt <= 2'h0;
    else if (ce_in)
      acq_cnt <= !track_out ? 2'h0 : (sclk_fall ? acq_cnt + 2'h1 : acq_cnt);

  sequence strobe_high_s;
    conversion_strobe_out && state == adc_serial_pkg::ST_STROBE;
  endsequence

  dout_release_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && sel_hi |=> dout_oe_n_out) else $error("data driven while deselected");
  dout_edge_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $changed(dout_out) |-> $past(sclk_fall)) else $error("data changed off falling edge");
  select_ignore_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && sel_hi && state != adc_serial_pkg::ST_INT_CONV |=> state == adc_serial_pkg::ST_IDLE)
    else $error("input accepted while deselected");
  int_strobe_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == adc_serial_pkg::ST_INT_CONV && $past(state) == adc_serial_pkg::ST_INT_CONV |-> !conversion_strobe_out)
    else $error("strobe high during internal conversion");
  ext_strobe_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    strobe_high_s ##0 (ce_in && sclk_fall && !sel_hi) |=> !conversion_strobe_out && bit_idx == 4'hA)
    else $error("strobe pulse not ended by MSB decision");
  strobe_hiz_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && sel_hi && !mode_int |=> conversion_strobe_oe_n_out) else $error("strobe driven while deselected");
  acq_window_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(track_out) && hold_on_negative_out |-> acq_cnt == `ACQ_CYCLES) else $error("acquisition not three cycles");
  track_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(track_out) |-> $past(bit_cnt) == `TRACK_BIT && $past(sclk_fall)) else $error("tracking started late");
  hold_switch_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(hold_on_negative_out) |-> !track_out) else $error("negative switched while tracking");
  common_return_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !neg_to_common_out |-> neg_channel_out == (pos_channel_out ^ 3'h1)) else $error("pair not adjacent");

endmodule // serial_adc_interface

`default_nettype wire

/* File: common/adc_serial_defines.svh */
// Purpose: Constants of the serial converter interface block.
// Assumes: Core clock of 200 MHz; control byte of eight bits.
// Notes:   Offsets are word indices on the plain register port.
// Function
// - Output data changes on falling serial clock; high impedance while select high.
// - Input data sampled on rising serial clock; host keeps it stable there.
// - Input ignored while select high; host holds select low while shifting.
// - Internal clock mode: strobe low at conversion start, high when done.
// - External clock mode: strobe high one serial period before MSB decision.
// - External clock mode: strobe high impedance while select high.
// - Each conversion yields a 12-bit result by successive approximation.
// - Acquisition window lasts three serial clock cycles.
// - Acquisition closes on falling edge after final control bit.
// - Conversion starts by switching hold capacitor to negative input.
// - Single-ended: selected input positive, negative tied to common return.
// - Differential: inputs taken from pair 0/1, 2/3, 4/5 or 6/7.
// - Three bits after start choose the input or input pair.
// - Tracking starts on falling edge after fifth control bit.
`ifndef ADC_SERIAL_DEFINES_SVH
`define ADC_SERIAL_DEFINES_SVH

//----------------------------------------
// Frame and result layout
//----------------------------------------
`define RESULT_BITS   12
`define CTRL_BITS     4'h8
`define TRACK_BIT     4'h5
`define ACQ_CYCLES    2'h3
`define MODE_INTERNAL 2'h2

//----------------------------------------
// Timing
//----------------------------------------
`define CORE_CLK_NS   5
`define INT_STEP_NS   100
`define INT_STEP_CYC  ((`INT_STEP_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

//----------------------------------------
// Register port map and reset values
//----------------------------------------
`define REG_STATUS    2'h0
`define REG_MASK      2'h1
`define REG_RESULT    2'h2
`define ST_DONE       0
`define ST_CTRL       1
`define MASK_RESET    2'h0

`endif

/* File: common/adc_serial_pkg.sv */
// Purpose: Types of the serial converter interface block.
// Assumes: Constants live in adc_serial_defines.svh.
// Notes:   States use explicit binary codes.
package adc_serial_pkg;

  //----------------------------------------
  // Frame sequencer states
  //----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_CONTROL  = 3'b001,
    ST_STROBE   = 3'b010,
    ST_EXT_CONV = 3'b011,
    ST_INT_CONV = 3'b100,
    ST_INT_READ = 3'b101
  } state_t;

endpackage

/* File: dv/host_model.sv */
// Purpose: Host side model driving the select, serial clock and data pins.
// Assumes: Serial clock of 80 ns, idle low, edges kept off the core edges.
// Notes:   Frame task snapshots the pins just before each rise.
`timescale 1ns/100ps
`default_nettype none

module host_model
(
  // Serial pins
  output logic            select_n_out,
  output logic            sclk_out,
  output logic            din_out,
  input  wire logic       dout_in,
  input  wire logic       strobe_in,
  // Track, hold_neg, strobe, common, pos, neg
  input  wire logic [9:0] view_in
);
  //------------------------------
  // Idle pins
  //------------------------------
  // Data idles high between frames
  initial
  begin
    select_n_out = 1'b1;
    sclk_out     = 1'b0;
    din_out      = 1'b1;
  end

  // Even duty, so conversion pacing stays legal
  task automatic pulse();
    sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask

  // Clocks while deselected must leave the port idle
  task automatic noise();
    for (int i = 0; i < 4; i++)
    begin
      #40;
      pulse();
    end
  endtask

  // Control byte MSB first, then clocks; stop below 20 aborts
  task automatic frame(input logic [7:0] ctrl, input bit intl, input int stop, output logic [11:0] rx,
                       output logic [9:0] s9, output logic t5, output logic t6, output logic st10,
                       output logic up);
    rx = 12'h000;
    up = 1'b0;
    select_n_out = 1'b0;
    #20.3;
    for (int i = 1; i <= (intl ? 8 : stop); i++)
    begin
      din_out = (i <= 8) ? ctrl[8 - i] : 1'b0;
      #40;
      if (i == 5) t5 = view_in[9];
      if (i == 6) t6 = view_in[9];
      if (i == 9) s9 = view_in;
      if (i == 10) st10 = strobe_in;
      if (i >= 10) rx = {rx[10:0], dout_in};
      pulse();
    end
    // Internal mode: wait bounded for the strobe, then read out
    if (intl)
    begin
      #40;
      s9 = view_in;
      for (int w = 0; w < 400 && strobe_in !== 1'b1; w++) #5;
      up = strobe_in;
      for (int k = 0; k < 13; k++)
      begin
        #40;
        if (k > 0) rx = {rx[10:0], dout_in};
        pulse();
      end
    end
    #40;
    select_n_out = 1'b1;
    din_out = 1'b1;
    #40;
  endtask
endmodule // host_model
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench of the serial converter port.
// Assumes: Comparator modelled from a digital target level.
// Notes:   Seeded random bytes and levels, corner levels first.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  //------------------------------
  // Signals
  //------------------------------
  logic        core_clk_in, rst_in, ce_in, comparator_in;
  logic        select_n_in, sclk_in, din_in, dout_out, dout_oe_n_out;
  logic        conversion_strobe_out, conversion_strobe_oe_n_out, neg_to_common_out;
  logic        track_out, hold_on_negative_out, polarity_select_out, irq_out;
  logic [2:0]  pos_channel_out, neg_channel_out;
  logic [11:0] dac_code_out, level, rx, lv;
  logic [1:0]  reg_addr_in, msk;
  logic [31:0] reg_wdata_in, reg_rdata_out, d;
  logic        reg_wr_in, reg_rd_in, t5, t6, st10, up;
  logic [9:0]  s9;
  logic [7:0]  ctrl;
  int          checks, miscompares, cycles;
  // Released pins float, so a stale bit cannot pass
  wire logic   dout_line   = dout_oe_n_out ? 1'bz : dout_out;
  wire logic   strobe_line = conversion_strobe_oe_n_out ? 1'bz : conversion_strobe_out;
  wire logic [9:0] view    = {track_out, hold_on_negative_out, conversion_strobe_out, neg_to_common_out,
                              pos_channel_out, neg_channel_out};

  serial_adc_interface serial_adc_interface_inst
  (
    .core_clk_in, .rst_in, .ce_in, .select_n_in, .sclk_in, .din_in, .dout_out, .dout_oe_n_out,
    .conversion_strobe_out, .conversion_strobe_oe_n_out, .comparator_in, .pos_channel_out,
    .neg_channel_out, .neg_to_common_out, .track_out, .hold_on_negative_out, .dac_code_out,
    .polarity_select_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out
  );

  host_model host_model_inst
  (
    .select_n_out(select_n_in), .sclk_out(sclk_in), .din_out(din_in),
    .dout_in(dout_line), .strobe_in(strobe_line), .view_in(view)
  );

  //------------------------------
  // Clock, comparator, timeout
  //------------------------------
  initial core_clk_in = 1'b0;
  always #2.5 core_clk_in = ~core_clk_in;

  // Input at or above trial code keeps the bit, so the result equals the level
  always @(posedge core_clk_in) comparator_in <= (level >= dac_code_out);

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      complete_run();
    end
  end

  //------------------------------
  // Tasks
  //------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // Expected track, hold, strobe, common and positive input after the byte
  function automatic logic [6:0] exp_view(input logic [7:0] c, input bit intl);
    return {1'b0, 1'b1, ~intl, c[2], c[5], c[4], c[6]};
  endfunction

  // One full conversion and its register side effects
  task automatic run(input logic [7:0] c, input logic [11:0] v, input logic [1:0] m);
    bit intl;
    intl = (c[1:0] == 2'b10);
    level <= v;
    reg_write(2'h1, {30'h0, m});
    host_model_inst.frame(c, intl, 21, rx, s9, t5, t6, st10, up);
    chk("result bits", v, rx);
    chk("dac code", v, dac_code_out);
    chk("track before", 0, t5);
    chk("track after", 1, t6);
    chk("conversion view", exp_view(c, intl), s9[9:3]);
    if (!c[2])
      chk("negative input", {c[5], c[4], c[6]} ^ 3'h1, s9[2:0]);
    if (intl)
      chk("strobe done", 1, up);
    else
      chk("strobe pulse end", 0, st10);
    chk("polarity", c[3], polarity_select_out);
    chk("dout released", 1, dout_oe_n_out);
    chk("strobe released", !intl, conversion_strobe_oe_n_out);
    chk("irq level", |m, irq_out);
    reg_read(2'h0, d);
    chk("status", 3, d);
    chk("irq cleared", 0, irq_out);
    reg_read(2'h2, d);
    chk("result reg", {13'h0, c[6:0], v}, d);
  endtask

  //------------------------------
  // Main sequence
  //------------------------------
  initial
  begin
    void'($urandom(58));
    rst_in        = 1'b1;
    ce_in         = 1'b1;
    reg_addr_in   = 2'h0;
    reg_wdata_in  = 32'h0;
    reg_wr_in     = 1'b0;
    reg_rd_in     = 1'b0;
    level         = 12'h000;
    comparator_in = 1'b0;
    checks        = 0;
    miscompares   = 0;
    cycles        = 0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    reg_read(2'h1, d);
    chk("mask reset", 0, d);
    reg_read(2'h3, d);
    chk("unmapped read", 0, d);
    host_model_inst.noise();
    reg_read(2'h0, d);
    chk("status deselected", 0, d);
    // Every channel code in both configurations and both clock modes
    for (int i = 0; i < 16; i++)
    begin
      ctrl = {1'b1, i[2:0], 1'($urandom), i[3], (i[0] ^ i[3]) ? 2'b10 : 2'b11};
      lv   = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      msk  = 2'($urandom);
      run(ctrl, lv, msk);
    end
    // Enable low freezes all state, so this mask write must not land
    reg_write(2'h1, 32'h0000_0001);
    ce_in <= 1'b0;
    reg_write(2'h1, 32'h0000_0002);
    ce_in <= 1'b1;
    reg_read(2'h1, d);
    chk("mask frozen", 1, d);
    // Select raised mid-conversion, then a write to read-only status
    host_model_inst.frame(8'hFF, 1'b0, 12, rx, s9, t5, t6, st10, up);
    chk("abort released", 1, dout_oe_n_out);
    reg_read(2'h0, d);
    chk("abort status", 2, d);
    reg_write(2'h0, 32'hFFFF_FFFF);
    reg_read(2'h0, d);
    chk("status read only", 0, d);
    run(8'hFF, 12'h5A3, 2'h3);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
